/* File: logic/rsd_consts.vh */
// Constants for the receive signaling debounce and freeze block.
// Included by the top design file only; holds definitions only.
`ifndef RSD_CONSTS_VH
`define RSD_CONSTS_VH
`define RSD_ADDR_W 9
`define RSD_CFG_ADDR 9'h0D7
`define RSD_STKEN_BASE 9'h180
`define RSD_SIGBUF_BASE 9'h1A0
`define RSD_PATTERN_ADDR 9'h1C0
`define RSD_ENTRY_SEL 9'h1E0
`define RSD_CFG_RESET 7'h00
`define RSD_PATTERN_RESET 4'hF
`define RSD_CFG_TRANSPARENT 0
`define RSD_CFG_FRZ_HOLD 1
`define RSD_CFG_FRZ_RELEASE 2
`define RSD_CFG_DEBOUNCE 3
`define RSD_CFG_PATTERN_EN 4
`define RSD_CFG_OVERWRITE 5
`define RSD_CFG_FORCE_IRQ 6
`define RSD_CFG_MASK 8'h7F
`define RSD_SIG_FRAME_A 5'h06
`define RSD_SIG_FRAME_B 5'h0C
`define RSD_SIG_FRAME_C 5'h12
`define RSD_SIG_FRAME_D 5'h18
`endif

/* File: logic/rsd_chan.v */
// Per-channel signaling update decision for one multiframe end.
// Pure combinational; the caller stores the results in its channel entry.
`timescale 1ns/1ps
module rsd_chan (
  input wire [3:0] new_in,      // ABCD received this multiframe
  input wire [3:0] buf_in,      // Buffered input nibble
  input wire [3:0] buf_out,     // Buffered output nibble
  input wire debounce,          // Debounce control
  input wire stack_en,          // Channel stack enable
  output reg [3:0] out_next,    // Next buffered output nibble
  output reg differ             // Next output nibble differs from buffered output
);
  integer i;
  always @*
  begin
    out_next = buf_in;
    differ = (buf_in != buf_out);
    if (debounce && stack_en)
    begin
      for (i = 0; i < 4; i = i + 1)
      begin
        // Agreement of two multiframes moves the bit; a lone flip is rejected
        if (new_in[i] == buf_in[i])
          out_next[i] = new_in[i];
        else
          out_next[i] = buf_out[i];
      end
      differ = (out_next != buf_out);
    end
  end
endmodule

/* File: logic/rsd_top.v */
// Receive signaling configuration: robbed-bit overwrite, inband freeze, debounce, interrupt select.
// Assumes the receive framer runs on the same clock and delivers one ABCD word per channel
// after the D bit of each multiframe, plus a multiframe boundary pulse and the PCM byte stream.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "rsd_consts.vh"
module rsd_top (
  input wire clock,                     // 10 MHz system clock
  input wire nrst,                      // Asynchronous reset, active low
  input wire [8:0] addr,                // Register address
  input wire [7:0] wr_data,             // Register write data
  input wire wr_en,                     // Write strobe
  input wire rd_en,                     // Read strobe
  output reg [7:0] rd_data,             // Read data, cycle after strobe
  input wire t1_mode,                   // High in T1 mode
  input wire rx_idle_insert,            // Idle insertion active
  input wire mf_boundary,               // One-cycle multiframe boundary pulse
  input wire abcd_valid,                // One-cycle ABCD word strobe
  input wire [4:0] abcd_chan,           // Channel of the ABCD word
  input wire [3:0] abcd_data,           // Received ABCD bits
  input wire pcm_valid,                 // PCM time slot strobe
  input wire [4:0] pcm_frame,           // Frame number in multiframe, 1..24
  input wire [7:0] pcm_byte,            // Time slot byte, bit 8 in position 0
  output reg pcm_out_valid,             // Strobe toward receive slip buffer
  output reg [7:0] pcm_out_byte,        // Byte toward receive slip buffer
  output reg stack_wr,                  // Signaling stack write pulse
  output reg [4:0] stack_chan,          // Channel written to stack
  output reg [3:0] stack_abcd,          // ABCD written to stack
  output reg sig_irq,                   // Signaling interrupt pulse
  output reg sig_freeze_pin,            // Freeze output pin level
  output reg transparent_robbed_bit     // Transparent mode level
);
  reg rst_meta_reg;
  reg rst_n_reg;
  reg [6:0] rx_sig_config_reg;
  reg [3:0] freeze_pattern_reg;
  reg [31:0] per_channel_stack_enable;
  reg [7:0] rx_sig_buffer [0:31];
  wire force_sig_irq_per_multiframe;
  wire overwrite_robbed_bit;
  wire inband_freeze_pattern_enable;
  wire debounce_en;
  wire freeze_hold_ctl;
  wire freeze_release_ctl;
  wire [7:0] cur_entry;
  wire [3:0] out_next;
  wire differ;
  wire frozen;
  wire chan_stack_en;
  wire commit;
  reg is_sig_frame;
  wire overwrite_slot;
  wire stack_change;
  reg [7:0] rd_next;

  assign force_sig_irq_per_multiframe = rx_sig_config_reg[`RSD_CFG_FORCE_IRQ];
  assign overwrite_robbed_bit = rx_sig_config_reg[`RSD_CFG_OVERWRITE];
  assign inband_freeze_pattern_enable = rx_sig_config_reg[`RSD_CFG_PATTERN_EN];
  assign debounce_en = rx_sig_config_reg[`RSD_CFG_DEBOUNCE];
  assign freeze_hold_ctl = rx_sig_config_reg[`RSD_CFG_FRZ_HOLD];
  assign freeze_release_ctl = rx_sig_config_reg[`RSD_CFG_FRZ_RELEASE];
  assign cur_entry = rx_sig_buffer[abcd_chan];
  assign chan_stack_en = per_channel_stack_enable[abcd_chan];

  // Reset release through two flops; assertion stays asynchronous
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  rsd_chan u_chan (
    .new_in(abcd_data),
    .buf_in(cur_entry[3:0]),
    .buf_out(cur_entry[7:4]),
    .debounce(debounce_en),
    .stack_en(chan_stack_en),
    .out_next(out_next),
    .differ(differ)
  );

  // Per-channel match only; nothing of it reaches a status bit or the pin
  assign frozen = t1_mode && inband_freeze_pattern_enable && (abcd_data == freeze_pattern_reg);
  // Non-debounced channels refresh on every unfrozen word; debounced ones only on a real change
  assign commit = abcd_valid && !frozen && (differ || !(debounce_en && chan_stack_en));

  // Configuration and pattern registers
  always @(posedge clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      rx_sig_config_reg <= `RSD_CFG_RESET;
      freeze_pattern_reg <= `RSD_PATTERN_RESET;
      per_channel_stack_enable <= 32'h00000000;
    end
    else if (wr_en)
    begin
      if (addr == `RSD_CFG_ADDR)
        rx_sig_config_reg <= wr_data[6:0];
      if (addr == `RSD_PATTERN_ADDR)
        freeze_pattern_reg <= wr_data[3:0];
      if ((addr & `RSD_ENTRY_SEL) == `RSD_STKEN_BASE)
        per_channel_stack_enable[addr[4:0]] <= wr_data[0];
    end
  end

  // Signaling buffer entries; software cannot write them
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1)
    begin : g_entry
      always @(posedge clock or negedge rst_n_reg)
      begin
        if (!rst_n_reg)
          rx_sig_buffer[g] <= 8'h00;
        else if (abcd_valid && !frozen && (abcd_chan == g))
        begin
          if (commit)
            rx_sig_buffer[g] <= {out_next, abcd_data};
          else
            rx_sig_buffer[g] <= {cur_entry[7:4], abcd_data};
        end
      end
    end
  endgenerate

  // Robbed-bit signaling frames of the multiframe
  always @*
  begin
    case (pcm_frame)
      `RSD_SIG_FRAME_A: is_sig_frame = 1'b1;
      `RSD_SIG_FRAME_B: is_sig_frame = 1'b1;
      `RSD_SIG_FRAME_C: is_sig_frame = 1'b1;
      `RSD_SIG_FRAME_D: is_sig_frame = 1'b1;
      default: is_sig_frame = 1'b0;
    endcase
  end

  assign overwrite_slot = pcm_valid && t1_mode && overwrite_robbed_bit && !rx_idle_insert && is_sig_frame;
  // A stack write needs an enabled channel and a real change of the output nibble
  assign stack_change = commit && chan_stack_en && (out_next != cur_entry[7:4]);

  always @*
  begin
    rd_next = 8'h00;
    if (addr == `RSD_CFG_ADDR)
      rd_next = {1'b0, rx_sig_config_reg};
    else if (addr == `RSD_PATTERN_ADDR)
      rd_next = {4'h0, freeze_pattern_reg};
    else if ((addr & `RSD_ENTRY_SEL) == `RSD_STKEN_BASE)
      rd_next = {7'h00, per_channel_stack_enable[addr[4:0]]};
    else if ((addr & `RSD_ENTRY_SEL) == `RSD_SIGBUF_BASE)
      rd_next = rx_sig_buffer[addr[4:0]];
  end

  // Read data stands for one cycle and is zero otherwise
  always @(posedge clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      rd_data <= 8'h00;
    else if (rd_en)
      rd_data <= rd_next;
    else
      rd_data <= 8'h00;
  end

  // Slot bytes toward the receive slip buffer, one cycle of latency
  always @(posedge clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      pcm_out_valid <= 1'b0;
      pcm_out_byte <= 8'h00;
    end
    else
    begin
      pcm_out_valid <= pcm_valid;
      // Bit 8 only; voice bits pass untouched
      if (overwrite_slot)
        pcm_out_byte <= {pcm_byte[7:1], 1'b1};
      else
        pcm_out_byte <= pcm_byte;
    end
  end

  // Stack write carries the channel and its new output nibble
  always @(posedge clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      stack_wr <= 1'b0;
      stack_chan <= 5'h00;
      stack_abcd <= 4'h0;
    end
    else
    begin
      stack_wr <= stack_change;
      stack_chan <= abcd_chan;
      stack_abcd <= out_next;
    end
  end

  // Forced boundary interrupts replace the stack-change interrupt rather than add to it
  always @(posedge clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      sig_irq <= 1'b0;
    else if (t1_mode && force_sig_irq_per_multiframe)
      sig_irq <= mf_boundary;
    else
      sig_irq <= stack_change;
  end

  // Pin levels follow the control bits only
  always @(posedge clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      sig_freeze_pin <= 1'b0;
      transparent_robbed_bit <= 1'b0;
    end
    else
    begin
      sig_freeze_pin <= freeze_hold_ctl && !freeze_release_ctl;
      transparent_robbed_bit <= rx_sig_config_reg[`RSD_CFG_TRANSPARENT];
    end
  end
endmodule

/* File: sim/rsd_framer_model.sv */
// Receive framer stand-in: delivers one ABCD word per request.
// Assumes requests arrive one cycle ahead of the word it puts out.
`timescale 1ns/1ps
module rsd_framer_model (
  input wire clock, // System clock
  input wire go, // Send one word
  input wire [4:0] chan, // Channel to send
  input wire [3:0] data, // ABCD to send
  output reg abcd_valid = 1'b0, // Word strobe
  output reg [4:0] abcd_chan = 5'h00, // Word channel
  output reg [3:0] abcd_data = 4'h0 // Word bits
);
  // Outside a word the lines toggle so stale values are never taken as valid
  always @(posedge clock)
  begin
    abcd_valid <= go;
    abcd_chan <= go ? chan : ~abcd_chan;
    abcd_data <= go ? data : ~abcd_data;
  end
endmodule

/* File: sim/rsd_assertions.sv */
// Port checks for the receive signaling block.
// Shadows config, pattern and stack enables from bus writes.
`timescale 1ns/1ps
module rsd_assertions (
  input wire clock, // Clock
  input wire nrst, // Reset
  input wire [8:0] addr, // Address
  input wire [7:0] wr_data, // Write data
  input wire wr_en, // Write strobe
  input wire t1_mode, // T1 mode
  input wire rx_idle_insert, // Idle insertion
  input wire mf_boundary, // Multiframe pulse
  input wire abcd_valid, // Word strobe
  input wire [4:0] abcd_chan, // Word channel
  input wire [3:0] abcd_data, // Word bits
  input wire pcm_valid, // Slot strobe
  input wire [4:0] pcm_frame, // Frame number
  input wire [7:0] pcm_byte, // Slot byte
  input wire pcm_out_valid, // Slot out strobe
  input wire [7:0] pcm_out_byte, // Slot out byte
  input wire stack_wr, // Stack write
  input wire [4:0] stack_chan, // Stack channel
  input wire sig_irq, // Interrupt
  input wire sig_freeze_pin, // Freeze pin
  input wire transparent_robbed_bit // Transparent level
);
  reg [7:0] cfg;
  reg [3:0] pat;
  reg [31:0] sen;
  wire ow = t1_mode && cfg[5] && !rx_idle_insert && (pcm_frame == 5'h06 || pcm_frame == 5'h0C
    || pcm_frame == 5'h12 || pcm_frame == 5'h18);
  wire fi = t1_mode && cfg[6];
  always @(posedge clock or negedge nrst)
    if (!nrst)
    begin
      cfg <= 8'h00;
      pat <= 4'hF;
      sen <= 32'h0;
    end
    else if (wr_en)
    begin
      if (addr == 9'h0D7) cfg <= wr_data;
      if (addr == 9'h1C0) pat <= wr_data[3:0];
      if (addr[8:5] == 4'hC) sen[addr[4:0]] <= wr_data[0];
    end
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence cfg_steady;
    $stable(cfg) [*2];
  endsequence
  a_pcm_overwrite: assert property (pcm_valid && ow |=> pcm_out_valid && pcm_out_byte[0])
    else $error("robbed bit not forced");
  a_pcm_pass: assert property (pcm_valid && !ow |=> pcm_out_byte == $past(pcm_byte))
    else $error("slot byte altered");
  a_force_irq: assert property (mf_boundary && fi |=> sig_irq)
    else $error("no interrupt at boundary");
  a_irq_follows_stack: assert property (!fi && !$past(fi) |-> sig_irq == stack_wr)
    else $error("interrupt not tied to stack");
  a_freeze_pin_level: assert property (cfg_steady |-> sig_freeze_pin == (cfg[1] && !cfg[2]))
    else $error("freeze pin level wrong");
  a_frozen_quiet: assert property (abcd_valid && t1_mode && cfg[4] && abcd_data == pat |=> !stack_wr)
    else $error("frozen channel written");
  a_stack_enable: assert property (abcd_valid && !sen[abcd_chan] |=> !stack_wr)
    else $error("disabled channel written");
  a_stack_source: assert property (stack_wr |-> $past(abcd_valid) && stack_chan == $past(abcd_chan))
    else $error("stack write without word");
  a_transparent_level: assert property (cfg_steady |-> transparent_robbed_bit == cfg[0])
    else $error("transparent level wrong");
endmodule
bind rsd_top rsd_assertions i_chk (.clock(clock), .nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
  .t1_mode(t1_mode), .rx_idle_insert(rx_idle_insert), .mf_boundary(mf_boundary), .abcd_valid(abcd_valid),
  .abcd_chan(abcd_chan), .abcd_data(abcd_data), .pcm_valid(pcm_valid), .pcm_frame(pcm_frame),
  .pcm_byte(pcm_byte), .pcm_out_valid(pcm_out_valid), .pcm_out_byte(pcm_out_byte), .stack_wr(stack_wr),
  .stack_chan(stack_chan), .sig_irq(sig_irq), .sig_freeze_pin(sig_freeze_pin),
  .transparent_robbed_bit(transparent_robbed_bit));

/* File: sim/rsd_top_test.sv */
// Self-checking bench for the receive signaling block.
// Drives registers, slot bytes and ABCD words; a monitor compares against queued expectations.
`timescale 1ns/1ps
module rsd_top_test;
  reg clock = 0, nrst = 0, wr_en = 0, rd_en = 0, idle = 0, t1 = 1, mfb = 0, pv = 0, go = 0, rq = 0;
  reg [8:0] addr = 0;
  reg [7:0] wd = 0, pb = 0, b, c, en, ent [0:7];
  reg [4:0] pf = 0, ch = 0;
  reg [3:0] dat = 0;
  integer error_cnt = 0, num_checks = 0, cyc = 0, i, p;
  logic [8:0] rqq[$], pq[$], sq[$];
  wire [7:0] rdd, pob;
  wire pov, swr, av;
  wire [4:0] sch, ac;
  wire [3:0] sab, ad;
  always #50 clock = ~clock;
  rsd_framer_model i_fm (.clock(clock), .go(go), .chan(ch), .data(dat), .abcd_valid(av), .abcd_chan(ac),
    .abcd_data(ad));
  rsd_top i_dut (.clock(clock), .nrst(nrst), .addr(addr), .wr_data(wd), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rdd), .t1_mode(t1), .rx_idle_insert(idle), .mf_boundary(mfb), .abcd_valid(av), .abcd_chan(ac),
    .abcd_data(ad), .pcm_valid(pv), .pcm_frame(pf), .pcm_byte(pb), .pcm_out_valid(pov), .pcm_out_byte(pob),
    .stack_wr(swr), .stack_chan(sch), .stack_abcd(sab), .sig_irq(), .sig_freeze_pin(), .transparent_robbed_bit());
  task chk(input [8:0] seen, input [8:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input [8:0] a, input [7:0] d);
    @(posedge clock);
    wr_en <= 1;
    addr <= a;
    wd <= d;
    @(posedge clock);
    wr_en <= 0;
  endtask
  task rd(input [8:0] a, input [7:0] e);
    @(posedge clock);
    rd_en <= 1;
    addr <= a;
    rqq.push_back({1'b0, e});
    @(posedge clock);
    rd_en <= 0;
  endtask
  task send(input [2:0] n, input [3:0] d);
    reg [3:0] o;
    o = ent[n][3:0];
    if (c[3] && en[n]) o = (~(d ^ ent[n][3:0]) & d) | ((d ^ ent[n][3:0]) & ent[n][7:4]);
    if (!(p != 4 && c[4] && d == 4'h6))
    begin
      if (en[n] && o != ent[n][7:4]) sq.push_back({2'b00, n, o});
      ent[n] = {o, d};
    end
    @(posedge clock);
    go <= 1;
    ch <= {2'b00, n};
    dat <= d;
    mfb <= 1;
    @(posedge clock);
    go <= 0;
    mfb <= 0;
    rd({6'h34, n}, ent[n]);
  endtask
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (rq) chk({1'b0, rdd}, rqq.size() ? rqq.pop_front() : 9'h1FF);
    if (nrst && pov !== 1'b0) chk({1'b0, pob}, pq.size() ? pq.pop_front() : 9'h1FF);
    if (nrst && swr !== 1'b0) chk({sch, sab}, sq.size() ? sq.pop_front() : 9'h1FF);
    rq <= rd_en;
    if (cyc > 5000)
    begin
      error_cnt = error_cnt + 1;
      final_report;
    end
  end
  initial
  begin
    p = $urandom(32'haec1d650);
    repeat (4) @(posedge clock);
    nrst <= 1;
    repeat (3) @(posedge clock);
    rd(9'h0D7, 8'h00);
    rd(9'h1C0, 8'h0F);
    rd(9'h185, 8'h00);
    rd(9'h010, 8'h00);
    wr(9'h1A5, 8'h5A);
    rd(9'h1A5, 8'h00);
    wr(9'h0D7, 8'hFF);
    rd(9'h0D7, 8'h7F);
    wr(9'h0D7, 8'h02);
    rd(9'h0D7, 8'h02);
    wr(9'h1C0, 8'h06);
    for (p = 0; p < 4; p = p + 1)
    begin
      wr(9'h0D7, p[0] ? 8'h20 : 8'h00);
      idle <= p[1];
      for (i = 1; i < 25; i = i + 1)
      begin
        @(posedge clock);
        b = 8'($urandom);
        pv <= 1;
        pf <= i[4:0];
        pb <= b;
        pq.push_back({1'b0, b | {7'h00, p == 1 && i % 6 == 0}});
      end
      @(posedge clock);
      pv <= 0;
    end
    en = 8'($urandom);
    for (i = 0; i < 8; i = i + 1)
    begin
      wr({6'h30, i[2:0]}, {7'h00, en[i]});
      ent[i] = 8'h00;
    end
    for (p = 0; p < 5; p = p + 1)
    begin
      c = (p == 0) ? 8'h00 : (p == 1) ? 8'h08 : (p == 2) ? 8'h18 : 8'h58;
      wr(9'h0D7, c);
      t1 <= (p != 4);
      repeat (40) send(3'($urandom % 8), 4'($urandom % 16));
    end
    repeat (3) @(posedge clock);
    chk(9'(sq.size()), 9'h000);
    chk(9'(pq.size() + rqq.size()), 9'h000);
    final_report;
  end
  task final_report;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
endmodule
